// >>> include/dscr_pkg.sv
package dscr_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;           // Bits per serial word
  localparam int ADDR_HI   = 10;           // Address upper bit
  localparam int ADDR_LO   = 9;            // Address lower bit
  localparam int COMMIT_B  = 8;            // Level commit flag
  localparam int CODE_W    = 8;            // Attenuation code width

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [1:0] ADR_LEFT  = 2'h0; // Left attenuation
  localparam logic [1:0] ADR_RIGHT = 2'h1; // Right attenuation
  localparam logic [1:0] ADR_MODE  = 2'h2; // Mode control
  localparam logic [1:0] ADR_FMT   = 2'h3; // Format control

  // ----------------------------------------------------------------
  // Mode control fields
  // ----------------------------------------------------------------
  localparam int MODE_SILENCE_B = 0;       // Soft silence
  localparam int MODE_EMPH_B    = 1;       // Emphasis undo
  localparam int MODE_HALT_B    = 2;       // Converter halt
  localparam int MODE_WLEN_LO_B = 3;       // Word length low
  localparam int MODE_WLEN_HI_B = 4;       // Word length high

  // ----------------------------------------------------------------
  // Format control fields
  // ----------------------------------------------------------------
  localparam int FMT_I2S_B    = 0;         // I2S format
  localparam int FMT_POL_B    = 1;         // Frame clock polarity
  localparam int FMT_SHARED_B = 2;         // Shared gain select
  localparam int FMT_GENTLE_B = 3;         // Gentle filter select
  localparam int FMT_INV_B    = 4;         // Output invert
  localparam int FMT_CKDIV_B  = 5;         // Clock out divide
  localparam int FMT_RATE_LO  = 6;         // Rate select low
  localparam int FMT_RATE_HI  = 7;         // Rate select high
  localparam int FMT_ZDET_B   = 8;         // Silence detect mute

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LEVEL = 8'hFF; // 0 dB
  localparam logic [4:0] RST_MODE  = 5'h00; // All off, 16 bit
  localparam logic [8:0] RST_FMT   = 9'h080; // 44.1k rate, rest off

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_48K  = 2'h1; // 48 kHz
  localparam logic [1:0] RATE_44K  = 2'h2; // 44.1 kHz
  localparam logic [1:0] RATE_32K  = 2'h3; // 32 kHz

  typedef enum logic [2:0] {
    DSCR_FMT_RJ16,
    DSCR_FMT_RJ20,
    DSCR_FMT_RJ24,
    DSCR_FMT_LJ24,
    DSCR_FMT_I2S16,
    DSCR_FMT_I2S24,
    DSCR_FMT_RSVD
  } dscr_fmt_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ZERO_RUN_BCLK = 65536;    // Zero run in bit clocks

endpackage

// >>> rtl/dscr_zero_detect.sv
`timescale 1ns/1ps
`default_nettype none
module dscr_zero_detect #(
  parameter int RUN_LEN = dscr_pkg::ZERO_RUN_BCLK // Bit clocks of zeros
) (
  input  wire logic clock_in,          // System clock
  input  wire logic rst_b_in,          // Sync reset, active low
  input  wire logic enable_in,         // Detection enabled
  input  wire logic bclk_rise_in,      // Bit clock rising pulse
  input  wire logic data_in,           // Synced audio data
  output logic      zero_out           // Zero run reached
);

  // ----------------------------------------------------------------
  // Run counter
  // ----------------------------------------------------------------
  localparam int CW = $clog2(RUN_LEN + 1); // Counter width
  localparam logic [CW-1:0] LAST = CW'(RUN_LEN); // Terminal count

  logic [CW-1:0] cnt_r;                // Zero bit clocks seen
  logic [CW-1:0] cnt_nxt;              // Next count
  logic          zero_r;               // Registered flag
  logic          zero_nxt;             // Next flag

  // Count zero bits, restart on any one; saturate at the end
  always_comb begin
    cnt_nxt  = cnt_r;
    zero_nxt = zero_r;
    if (!enable_in) begin
      // Disabled: no automatic muting
      cnt_nxt  = '0;
      zero_nxt = 1'b0;
    end else if (bclk_rise_in) begin
      if (data_in) begin
        cnt_nxt  = '0;
        zero_nxt = 1'b0;
      end else if (cnt_r != LAST) begin
        cnt_nxt  = cnt_r + CW'(1);
        zero_nxt = (cnt_r + CW'(1)) == LAST;
      end
    end
  end

  // Register only
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cnt_r  <= '0;
      zero_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      zero_r <= zero_nxt;
    end
  end

  assign zero_out = zero_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_zero_off;
    @(posedge clock_in) disable iff (!rst_b_in)
      !enable_in |=> !zero_r;
  endproperty
  a_zero_off: assert property (p_zero_off)
    else $error("zero flag set while detection disabled");

endmodule
`default_nettype wire

// >>> rtl/dscr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dscr_regs #(
  parameter int ZERO_RUN = dscr_pkg::ZERO_RUN_BCLK // Zero run length
) (
  input  wire logic       clock_in,            // System clock 125 MHz
  input  wire logic       rst_b_in,            // Sync reset, active low
  input  wire logic       mode_select_in,      // High: software mode
  input  wire logic       control_latch_strobe_in, // Latch pin
  input  wire logic       control_shift_clock_in,  // Shift clock pin
  input  wire logic       control_serial_data_in,  // Serial data pin
  input  wire logic       frame_clock_in,      // Audio frame clock pin
  input  wire logic       bit_clock_in,        // Audio bit clock pin
  input  wire logic       audio_data_in,       // Audio data pin
  output logic [7:0]      left_level_out,      // Active left code
  output logic [7:0]      right_level_out,     // Active right code
  output logic            soft_silence_out,    // Soft mute both
  output logic            emphasis_undo_out,   // De-emphasis on
  output logic            force_zero_out,      // Bipolar zero out
  output logic [2:0]      audio_format_out,    // Decoded format
  output logic            format_reserved_out, // Reserved format code
  output logic [1:0]      emphasis_rate_out,   // De-emphasis rate
  output logic            gentle_filter_out,   // Slow roll-off
  output logic            output_invert_out,   // Invert phase
  output logic            clock_out_divide_out, // Halve clock out
  output logic            left_on_frame_high_out // Left on frame high
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] s1_r;                    // First stage, read only by s2
  logic [6:0] s2_r;                    // Second stage
  logic       sclk_d_r;                // Shift clock delayed
  logic       latch_d_r;               // Latch delayed
  logic       bclk_d_r;                // Bit clock delayed

  // Two flops on every pin before any logic
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      s1_r      <= 7'h00;
      s2_r      <= 7'h00;
      sclk_d_r  <= 1'b0;
      latch_d_r <= 1'b0;
      bclk_d_r  <= 1'b0;
    end else begin
      s1_r      <= {mode_select_in, audio_data_in, bit_clock_in,
                    frame_clock_in, control_latch_strobe_in,
                    control_shift_clock_in, control_serial_data_in};
      s2_r      <= s1_r;
      sclk_d_r  <= s2_r[1];
      latch_d_r <= s2_r[2];
      bclk_d_r  <= s2_r[4];
    end
  end

  logic sdata;                         // Synced serial data
  logic sclk_rise;                     // Shift clock rising
  logic latch_rise;                    // Latch strobe rising
  logic bclk_rise;                     // Bit clock rising
  logic mode_sw;                       // Synced mode strap
  // Strap is a pin too; reset low so defaults show until it settles
  assign mode_sw    = s2_r[6];
  assign sdata      = s2_r[0];
  assign sclk_rise  = s2_r[1] & ~sclk_d_r;
  assign latch_rise = s2_r[2] & ~latch_d_r;
  assign bclk_rise  = s2_r[4] & ~bclk_d_r;

  // ----------------------------------------------------------------
  // Shift register and write decode
  // ----------------------------------------------------------------
  localparam int W = dscr_pkg::WORD_BITS; // Word width

  logic [W-1:0] shift_r;               // Incoming word, MSB first
  logic [W-1:0] shift_nxt;             // Next shift contents
  logic [4:0]   nbits_r;               // Bits since last latch
  logic [4:0]   nbits_nxt;             // Next bit count
  logic         commit;                // Full word latched

  // Bits shift in on rising clock; latch clears the count. A word
  // never latched is simply overwritten by later bits.
  always_comb begin
    shift_nxt = shift_r;
    nbits_nxt = nbits_r;
    commit    = 1'b0;
    if (latch_rise) begin
      commit    = mode_sw && (nbits_r >= 5'(W));
      nbits_nxt = 5'h00;
    end else if (sclk_rise) begin
      shift_nxt = {shift_r[W-2:0], sdata};
      if (nbits_r != 5'h1F) begin
        nbits_nxt = nbits_r + 5'h01;
      end
    end
  end

  logic [1:0] addr;                    // Target register
  assign addr = shift_r[dscr_pkg::ADDR_HI:dscr_pkg::ADDR_LO];

  // ----------------------------------------------------------------
  // Program registers
  // ----------------------------------------------------------------
  logic [7:0] left_stage_r,  left_stage_nxt;   // Staged left code
  logic [7:0] right_stage_r, right_stage_nxt;  // Staged right code
  logic [7:0] left_act_r,    left_act_nxt;     // Active left code
  logic [7:0] right_act_r,   right_act_nxt;    // Active right code
  logic [4:0] mode_r,        mode_nxt;         // Mode control
  logic [8:0] fmt_r,         fmt_nxt;          // Format control

  // Register commit; reserved bits of each word are ignored
  always_comb begin
    left_stage_nxt  = left_stage_r;
    right_stage_nxt = right_stage_r;
    left_act_nxt    = left_act_r;
    right_act_nxt   = right_act_r;
    mode_nxt        = mode_r;
    fmt_nxt         = fmt_r;
    if (commit) begin
      case (addr)
        dscr_pkg::ADR_LEFT: begin
          left_stage_nxt = shift_r[7:0];
          if (shift_r[dscr_pkg::COMMIT_B]) begin
            left_act_nxt = shift_r[7:0];
          end
        end
        dscr_pkg::ADR_RIGHT: begin
          right_stage_nxt = shift_r[7:0];
          if (shift_r[dscr_pkg::COMMIT_B]) begin
            right_act_nxt = shift_r[7:0];
          end
        end
        dscr_pkg::ADR_MODE: begin
          mode_nxt = shift_r[4:0];
        end
        dscr_pkg::ADR_FMT: begin
          fmt_nxt = shift_r[8:0];
        end
        default: begin
          fmt_nxt = fmt_r;
        end
      endcase
    end
  end

  // Register only; reset restores defaults
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      shift_r       <= '0;
      nbits_r       <= 5'h00;
      left_stage_r  <= dscr_pkg::RST_LEVEL;
      right_stage_r <= dscr_pkg::RST_LEVEL;
      left_act_r    <= dscr_pkg::RST_LEVEL;
      right_act_r   <= dscr_pkg::RST_LEVEL;
      mode_r        <= dscr_pkg::RST_MODE;
      fmt_r         <= dscr_pkg::RST_FMT;
    end else begin
      shift_r       <= shift_nxt;
      nbits_r       <= nbits_nxt;
      left_stage_r  <= left_stage_nxt;
      right_stage_r <= right_stage_nxt;
      left_act_r    <= left_act_nxt;
      right_act_r   <= right_act_nxt;
      mode_r        <= mode_nxt;
      fmt_r         <= fmt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Zero detection
  // ----------------------------------------------------------------
  logic zero_run;                      // Long zero input seen

  dscr_zero_detect #(
    .RUN_LEN      (ZERO_RUN)
  ) u_zero (
    .clock_in     (clock_in),
    .rst_b_in     (rst_b_in),
    .enable_in    (mode_sw & fmt_r[dscr_pkg::FMT_ZDET_B]),
    .bclk_rise_in (bclk_rise),
    .data_in      (s2_r[5]),
    .zero_out     (zero_run)
  );

  // ----------------------------------------------------------------
  // Effective settings
  // ----------------------------------------------------------------
  // Outside software mode the defaults stand in for the registers
  logic [4:0] mode_eff;                // Mode in force
  logic [8:0] fmt_eff;                 // Format in force
  logic [7:0] lvl_l;                   // Left level in force
  logic [7:0] lvl_r;                   // Right level in force
  assign mode_eff = mode_sw ? mode_r : dscr_pkg::RST_MODE;
  assign fmt_eff  = mode_sw ? fmt_r  : dscr_pkg::RST_FMT;
  assign lvl_l    = mode_sw ? left_act_r : dscr_pkg::RST_LEVEL;
  assign lvl_r    = !mode_sw ? dscr_pkg::RST_LEVEL :
                    fmt_r[dscr_pkg::FMT_SHARED_B] ? left_act_r :
                    right_act_r;

  dscr_pkg::dscr_fmt_e fmt_dec;        // Decoded format
  logic [2:0]          fsel;           // {i2s, len hi, len lo}
  assign fsel = {fmt_eff[dscr_pkg::FMT_I2S_B],
                 mode_eff[dscr_pkg::MODE_WLEN_HI_B],
                 mode_eff[dscr_pkg::MODE_WLEN_LO_B]};

  // Word length and format decode
  always_comb begin
    case (fsel)
      3'h0:    fmt_dec = dscr_pkg::DSCR_FMT_RJ16;
      3'h1:    fmt_dec = dscr_pkg::DSCR_FMT_RJ20;
      3'h2:    fmt_dec = dscr_pkg::DSCR_FMT_RJ24;
      3'h3:    fmt_dec = dscr_pkg::DSCR_FMT_LJ24;
      3'h4:    fmt_dec = dscr_pkg::DSCR_FMT_I2S16;
      3'h5:    fmt_dec = dscr_pkg::DSCR_FMT_I2S24;
      default: fmt_dec = dscr_pkg::DSCR_FMT_RSVD;
    endcase
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [28:0] out_r;                  // Packed outputs
  logic [28:0] out_nxt;                // Next outputs

  always_comb begin
    out_nxt = {lvl_l, lvl_r,
               mode_eff[dscr_pkg::MODE_SILENCE_B],
               mode_eff[dscr_pkg::MODE_EMPH_B],
               mode_eff[dscr_pkg::MODE_HALT_B] | zero_run,
               3'(fmt_dec),
               fmt_dec == dscr_pkg::DSCR_FMT_RSVD,
               fmt_eff[dscr_pkg::FMT_RATE_HI:dscr_pkg::FMT_RATE_LO],
               fmt_eff[dscr_pkg::FMT_GENTLE_B],
               fmt_eff[dscr_pkg::FMT_INV_B],
               fmt_eff[dscr_pkg::FMT_CKDIV_B],
               ~fmt_eff[dscr_pkg::FMT_POL_B]};
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      out_r <= {dscr_pkg::RST_LEVEL, dscr_pkg::RST_LEVEL, 3'h0, 3'h0,
                1'b0, dscr_pkg::RATE_44K, 3'h0, 1'b1};
    end else begin
      out_r <= out_nxt;
    end
  end

  assign left_level_out         = out_r[28:21];
  assign right_level_out        = out_r[20:13];
  assign soft_silence_out       = out_r[12];
  assign emphasis_undo_out      = out_r[11];
  assign force_zero_out         = out_r[10];
  assign audio_format_out       = out_r[9:7];
  assign format_reserved_out    = out_r[6];
  assign emphasis_rate_out      = out_r[5:4];
  assign gentle_filter_out      = out_r[3];
  assign output_invert_out      = out_r[2];
  assign clock_out_divide_out   = out_r[1];
  assign left_on_frame_high_out = out_r[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_left_stage;
    commit && addr == dscr_pkg::ADR_LEFT && !shift_r[dscr_pkg::COMMIT_B];
  endsequence

  property p_stage_hold;
    @(posedge clock_in) disable iff (!rst_b_in)
      s_left_stage |=> $stable(left_act_r);
  endproperty
  a_stage_hold: assert property (p_stage_hold)
    else $error("staged left code changed active level");

  property p_commit_bits;
    @(posedge clock_in) disable iff (!rst_b_in)
      commit |-> nbits_r >= 5'h10;
  endproperty
  a_commit_bits: assert property (p_commit_bits)
    else $error("commit with fewer than sixteen bits");

  property p_shared;
    @(posedge clock_in) disable iff (!rst_b_in)
      mode_sw && fmt_r[dscr_pkg::FMT_SHARED_B] |=>
        right_level_out == left_level_out;
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared gain not applied to right");

  property p_halt;
    @(posedge clock_in) disable iff (!rst_b_in)
      mode_sw && mode_r[dscr_pkg::MODE_HALT_B] |=> force_zero_out;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not force zero");

  property p_hw_mode;
    @(posedge clock_in) disable iff (!rst_b_in)
      !mode_sw |=> $stable(left_act_r) && $stable(right_act_r) &&
                   $stable(mode_r) && $stable(fmt_r);
  endproperty
  a_hw_mode: assert property (p_hw_mode)
    else $error("register write outside software mode");

endmodule
`default_nettype wire

// >>> bench/dscr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host controller on the three-wire control port
// ----------------------------------------------------------------
module dscr_host_model (
  input  wire logic clock_in,   // Bench clock
  output var logic  latch_out,  // Latch strobe to device
  output var logic  shift_out,  // Shift clock to device
  output var logic  data_out    // Serial data to device
);
  // Idle levels at time zero; shift clock stands still low
  initial begin
    latch_out = 1'h0;
    shift_out = 1'h0;
    data_out  = 1'h0;
  end

  // Wait a number of system clock edges
  task automatic hold(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // ----------------------------------------------------------------
  // One word: bits MSB first, then a latch pulse
  // ----------------------------------------------------------------
  // Each level is held 4 clocks, above the 3 the sync chain needs
  task automatic send_word(input logic [15:0] word, input int nbits);
    for (int i = nbits - 1; i >= 0; i--) begin
      data_out  <= word[i];
      hold(4);
      shift_out <= 1'h1;
      hold(4);
      shift_out <= 1'h0;
    end
    hold(4);
    // Line released: show the inverse so a stale bit never counts
    data_out  <= ~data_out;
    latch_out <= 1'h1;
    hold(4);
    latch_out <= 1'h0;
    hold(4);
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Compare two values, count the compare and report any difference
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
  end \
end
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] word;   // Word sent by the host
    logic [7:0]  left;   // Expected left code
    logic [7:0]  right;  // Expected right code
    logic [12:0] misc;   // Silence,emph,zero,fmt,rsvd,rate,flt,inv,ck,pol
  } dscr_row_s;
  localparam int          NROWS = 19;                        // Table rows
  localparam logic [28:0] DEF   = {8'hFF, 8'hFF, 13'h0021}; // Defaults
  logic        clock_in, rst_b_in, mode_sel;  // Clock, reset, mode strap
  logic        latch, shift, sdata;           // Control port pins
  logic        frame, bclk, adata;            // Audio pins
  logic [7:0]  left, right;                   // Level outputs
  logic        sil, emph, fz, rsvd, flt, inv; // Single flags
  logic        ckdiv, lofh;                   // Clock divide, polarity
  logic [2:0]  fmt;                           // Decoded format
  logic [1:0]  rate;                          // Emphasis rate
  wire  [28:0] obs;                           // All outputs packed
  int          num_errors, checks;            // Counters
  dscr_row_s   rows [NROWS];                  // Ordinary cases
  logic [28:0] saved;                         // State before mode low
  logic [28:0] exp_row;                       // Expected row outputs

  assign obs = {left, right, sil, emph, fz, fmt, rsvd, rate, flt, inv,
                ckdiv, lofh};

  // Clock at 125 MHz
  initial begin
    clock_in = 1'h0;
    forever #4 clock_in = ~clock_in;
  end

  dscr_regs #(.ZERO_RUN(8)) DUT (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .mode_select_in(mode_sel),
    .control_latch_strobe_in(latch), .control_shift_clock_in(shift),
    .control_serial_data_in(sdata), .frame_clock_in(frame),
    .bit_clock_in(bclk), .audio_data_in(adata), .left_level_out(left),
    .right_level_out(right), .soft_silence_out(sil),
    .emphasis_undo_out(emph), .force_zero_out(fz),
    .audio_format_out(fmt), .format_reserved_out(rsvd),
    .emphasis_rate_out(rate), .gentle_filter_out(flt),
    .output_invert_out(inv), .clock_out_divide_out(ckdiv),
    .left_on_frame_high_out(lofh));

  dscr_host_model host (.clock_in(clock_in), .latch_out(latch),
    .shift_out(shift), .data_out(sdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Full word then settle; commit lands well inside 4 clocks
  task automatic write(input logic [15:0] w);
    host.send_word(w, 16);
    repeat (4) @(posedge clock_in);
  endtask

  // Bit clock pulses with constant audio data
  task automatic bit_run(input int n, input logic d);
    adata <= d;
    for (int i = 0; i < n; i++) begin
      bclk  <= 1'h1;
      frame <= ~frame;
      repeat (4) @(posedge clock_in);
      bclk  <= 1'h0;
      repeat (4) @(posedge clock_in);
    end
    repeat (8) @(posedge clock_in);
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clock_in);
    num_errors++;
    $display("watchdog expired");
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_in = 1'h0;
    mode_sel = 1'h1;
    frame = 1'h0;
    bclk = 1'h0;
    adata = 1'h0;
    num_errors = 0;
    checks = 0;
    // Cumulative rows; reserved bits always zero in every word
    rows = '{
      '{16'h0040, 8'hFF, 8'hFF, 13'h0021}, // Left staged only
      '{16'h0180, 8'h80, 8'hFF, 13'h0021}, // Left committed
      '{16'h0233, 8'h80, 8'hFF, 13'h0021}, // Right staged only
      '{16'h0300, 8'h80, 8'h00, 13'h0021}, // Right mute code
      '{16'h0401, 8'h80, 8'h00, 13'h1021}, // Soft silence
      '{16'h0402, 8'h80, 8'h00, 13'h0821}, // Emphasis undo
      '{16'h0404, 8'h80, 8'h00, 13'h0421}, // Converter halt
      '{16'h0408, 8'h80, 8'h00, 13'h00A1}, // 20-bit right
      '{16'h0410, 8'h80, 8'h00, 13'h0121}, // 24-bit right
      '{16'h0418, 8'h80, 8'h00, 13'h01A1}, // 24-bit left
      '{16'h0681, 8'h80, 8'h00, 13'h0361}, // I2S with 11: reserved
      '{16'h0400, 8'h80, 8'h00, 13'h0221}, // 16-bit I2S
      '{16'h0408, 8'h80, 8'h00, 13'h02A1}, // 24-bit I2S
      '{16'h0410, 8'h80, 8'h00, 13'h0361}, // I2S with 10: reserved
      '{16'h0640, 8'h80, 8'h00, 13'h0111}, // Rate 48k
      '{16'h06C0, 8'h80, 8'h00, 13'h0131}, // Rate 32k
      '{16'h063E, 8'h80, 8'h80, 13'h010E}, // Shared gain, polarity, filter, invert, divide
      '{16'h03AA, 8'h80, 8'h80, 13'h010E}, // Right ignored when shared
      '{16'h0600, 8'h80, 8'hAA, 13'h0101}  // Own right level again
    };
    repeat (2) @(posedge clock_in);
    `CHK(obs, DEF)
    repeat (18) @(posedge clock_in);
    rst_b_in <= 1'h1;
    @(posedge clock_in);
    $display("test reset done");
    // Table of ordinary writes
    for (int i = 0; i < NROWS; i++) begin
      write(rows[i].word);
      exp_row = {rows[i].left, rows[i].right, rows[i].misc};
      `CHK(obs, exp_row)
      $display("test row %0d done", i);
    end
    saved = obs;
    // Latch after only 15 bits must be dropped
    host.send_word(16'h0100, 15);
    repeat (4) @(posedge clock_in);
    `CHK(left, 8'h80)
    write(16'h0100);
    `CHK(left, 8'h00)
    write(16'h0180);
    $display("test short word done");
    // Mode strap low: defaults shown, registers kept
    mode_sel <= 1'h0;
    repeat (4) @(posedge clock_in);
    `CHK(obs, DEF)
    // A word sent while the strap is low must be refused
    write(16'h0100);
    `CHK(obs, DEF)
    mode_sel <= 1'h1;
    repeat (4) @(posedge clock_in);
    `CHK(obs, saved)
    $display("test mode strap done");
    // Zero run with detection off, then on, then broken by a one
    bit_run(12, 1'h0);
    `CHK(fz, 1'h0)
    write(16'h0780);
    bit_run(12, 1'h0);
    `CHK(fz, 1'h1)
    bit_run(2, 1'h1);
    `CHK(fz, 1'h0)
    // End points of the run: one short, then exactly the run length
    bit_run(7, 1'h0);
    `CHK(fz, 1'h0)
    bit_run(1, 1'h0);
    `CHK(fz, 1'h1)
    $display("test zero detect done");
    // Reset in mid-run restores every default
    rst_b_in <= 1'h0;
    repeat (3) @(posedge clock_in);
    `CHK(obs, DEF)
    rst_b_in <= 1'h1;
    repeat (2) @(posedge clock_in);
    `CHK(obs, DEF)
    $display("test mid reset done");
    test_done();
  end
endmodule
`default_nettype wire
